// file: rtl/pca_core.sv
// What this block does
// - 16-bit up-counter read as two bytes
// - Low-byte read snapshots high byte for next
// - Register reads never disturb counting
// - Three-bit field picks count timebase
// - Code 3 counts external falling edges
// - Code 5 counts synchronised oscillator over 8
// - Wrap to zero sets main overflow flag
// - Overflow enable raises request while flagged
// - Flag stays set until software clears
// - Idle control zero keeps counting in idle
// - Mid overflow from bit 7 to 14
// - Five event flags including three channels
// - Flags set regardless of enables
// - Request is any flag with enable
// - Reset enters watchdog mode, restricting access
// - Cycle length field picks mid bit
//
// Avalon-MM slave of the counter array, with interrupt tree.
// Assumes channel flags arrive as one-cycle pulses from channel logic.
`default_nettype none

module pca_core
  import pca_pkg::*;
(
  // Clock and reset
  input  wire logic         clk_sys,
  input  wire logic         reset,
  // Avalon-MM slave
  input  wire logic [3:0]   address,
  input  wire logic         read,
  input  wire logic         write,
  input  wire logic [31:0]  writedata,
  output logic [31:0]       readdata,
  output logic              waitrequest,
  // Count sources and processor state
  input  wire logic         timer_ovf,
  input  wire logic         ext_count_input,
  input  wire logic         ext_osc,
  input  wire logic         cpu_idle,
  // Channel interface
  input  wire logic [2:0]   channel_event,
  output logic [15:0]       count_value,
  output logic              watchdog_function,
  // Interrupt
  output logic              irq
);

  typedef struct packed {
    logic [15:0] count;
    logic [7:0]  snap;
    logic [7:0]  mode;
    logic [4:0]  status;
    logic [4:0]  enable;
    logic [2:0]  cycle_length_select;
    logic        ack;
    logic [31:0] rdata;
  } core_state_s;

  core_state_s st_r;
  core_state_s st_nxt;
  bus_req_s    req;
  logic        tick;
  logic        run;
  logic [16:0] count_inc;
  logic        mid_ovf;
  logic [4:0]  events;
  logic [4:0]  clear_mask;
  logic        take;
  logic        locked;

  // ---------------------------------------------------------------
  // Timebase
  // ---------------------------------------------------------------
  pca_tick_gen u_tick
  (
    .clk_sys         (clk_sys),
    .reset           (reset),
    .timebase_select (st_r.mode[MODE_TB_LSB +: 3]),
    .timer_ovf       (timer_ovf),
    .ext_count_input (ext_count_input),
    .ext_osc         (ext_osc),
    .tick            (tick)
  );

  // ---------------------------------------------------------------
  // Counter and events
  // ---------------------------------------------------------------
  // Idle only freezes the count when the idle control bit is set
  assign run = tick && !(cpu_idle && st_r.mode[MODE_IDLE_BIT]);
  assign count_inc = {1'b0, st_r.count} + 17'h00001;
  // Carry out of the selected bit: all ones below and at bit 7+sel
  always_comb
  begin
    mid_ovf = 1'b1;
    for (int b = 0; b < 16; b++)
      if (b <= 7 + int'(st_r.cycle_length_select))
        mid_ovf = mid_ovf & st_r.count[b];
    mid_ovf = mid_ovf & run;
  end
  assign events = {channel_event,
                   mid_ovf,
                   run && count_inc[16]};
  // Watchdog mode locks mode writes until it is turned off
  assign locked = st_r.mode[MODE_WDOG_BIT];

  // ---------------------------------------------------------------
  // Bus decode
  // ---------------------------------------------------------------
  assign req = '{read: read, write: write, address: address, writedata: writedata};
  assign take = (req.read || req.write) && !st_r.ack;
  assign waitrequest = (read || write) && !st_r.ack;
  assign clear_mask = (take && req.write && req.address == ADDR_STATUS)
                      ? req.writedata[NUM_EV-1:0] : 5'h00;

  // ---------------------------------------------------------------
  // Next state
  // ---------------------------------------------------------------
  always_comb
  begin
    st_nxt = st_r;
    st_nxt.ack = take;
    // Counting is independent of any read
    if (run)
      st_nxt.count = count_inc[15:0];
    // Write one clears; a same-cycle event wins
    st_nxt.status = (st_r.status & ~clear_mask) | events;
    if (take && req.read)
    begin
      st_nxt.rdata = 32'h0;
      case (req.address)
        ADDR_COUNT_LOW:
        begin
          st_nxt.rdata[7:0] = st_r.count[7:0];
          st_nxt.snap = st_r.count[15:8];
        end
        ADDR_COUNT_HIGH: st_nxt.rdata[7:0] = st_r.snap;
        ADDR_MODE:       st_nxt.rdata[7:0] = st_r.mode;
        ADDR_STATUS:     st_nxt.rdata[NUM_EV-1:0] = st_r.status;
        ADDR_ENABLE:     st_nxt.rdata[NUM_EV-1:0] = st_r.enable;
        ADDR_CYCLE_LEN:  st_nxt.rdata[2:0] = st_r.cycle_length_select;
        default:         st_nxt.rdata = 32'h0;
      endcase
    end
    if (take && req.write)
    begin
      case (req.address)
        ADDR_COUNT_LOW:
          if (!locked)
            st_nxt.count[7:0] = req.writedata[7:0];
        ADDR_COUNT_HIGH:
          if (!locked)
            st_nxt.count[15:8] = req.writedata[7:0];
        ADDR_MODE:
          // While locked only the watchdog bit itself may be cleared
          if (!locked)
            st_nxt.mode = req.writedata[7:0];
          else
            st_nxt.mode[MODE_WDOG_BIT] = req.writedata[MODE_WDOG_BIT];
        ADDR_ENABLE:    st_nxt.enable = req.writedata[NUM_EV-1:0];
        ADDR_CYCLE_LEN: st_nxt.cycle_length_select = req.writedata[2:0];
        default:        st_nxt.enable = st_r.enable;
      endcase
    end
  end

  // Registered state, synchronous reset to watchdog mode
  always_ff @(posedge clk_sys)
  begin
    if (reset)
    begin
      st_r <= '0;
      st_r.mode <= MODE_RESET;
    end
    else
      st_r <= st_nxt;
  end

  // ---------------------------------------------------------------
  // Outputs
  // ---------------------------------------------------------------
  assign readdata = st_r.rdata;
  assign count_value = st_r.count;
  assign watchdog_function = st_r.mode[MODE_WDOG_BIT];
  // Main overflow enable lives in the mode register, others in enable
  // The core still gates this with its own global switches
  assign irq = (st_r.status[ST_MAIN] && st_r.mode[MODE_OVF_IRQ])
             | (|(st_r.status[NUM_EV-1:ST_MID] & st_r.enable[NUM_EV-1:ST_MID]));

  // ---------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------
  sequence s_low_read;
    take && read && address == ADDR_COUNT_LOW;
  endsequence

  AST_WRAP_SETS_FLAG: assert property (@(posedge clk_sys) disable iff (reset)
    run && st_r.count == 16'hffff |=> st_r.status[ST_MAIN] && st_r.count == 16'h0000)
    else $error("wrap did not set main flag");
  AST_SNAPSHOT: assert property (@(posedge clk_sys) disable iff (reset)
    s_low_read |=> st_r.snap == $past(st_r.count[15:8]))
    else $error("snapshot not taken");
  AST_COUNT_STEP: assert property (@(posedge clk_sys) disable iff (reset)
    run && !write |=> st_r.count == $past(st_r.count) + 16'h0001)
    else $error("counter did not advance");
  AST_IDLE_HOLD: assert property (@(posedge clk_sys) disable iff (reset)
    cpu_idle && st_r.mode[MODE_IDLE_BIT] && !write |=> $stable(st_r.count))
    else $error("counter moved in idle");
  AST_FLAG_STICKY: assert property (@(posedge clk_sys) disable iff (reset)
    st_r.status[ST_MAIN] && !(take && write && address == ADDR_STATUS)
    |=> st_r.status[ST_MAIN])
    else $error("main flag dropped");
  AST_EVENT_SET: assert property (@(posedge clk_sys) disable iff (reset)
    channel_event[0] |=> st_r.status[ST_CH0])
    else $error("channel flag not set");
  AST_IRQ_ANY: assert property (@(posedge clk_sys) disable iff (reset)
    irq == ((st_r.status[ST_MAIN] && st_r.mode[MODE_OVF_IRQ])
            || (|(st_r.status[4:1] & st_r.enable[4:1]))))
    else $error("request mismatch");
  AST_MID_SET: assert property (@(posedge clk_sys) disable iff (reset)
    run && st_r.cycle_length_select == CLSEL_BASE && st_r.count[7:0] == 8'hff
    |=> st_r.status[ST_MID])
    else $error("mid flag not set");
  AST_ANSWER: assert property (@(posedge clk_sys) disable iff (reset)
    (read || write) && waitrequest |=> !waitrequest || !(read || write))
    else $error("answer late");

endmodule : pca_core

`default_nettype wire

// file: rtl/pca_pkg.sv
// Package for the counter array timebase and interrupt block.
// Assumes a single 10 MHz system clock and a 32-bit Avalon-MM slave port.
`default_nettype none

package pca_pkg;

  // ---------------------------------------------------------------
  // Register map (word addresses, one word each)
  // ---------------------------------------------------------------
  localparam logic [3:0] ADDR_COUNT_LOW  = 4'h0;
  localparam logic [3:0] ADDR_COUNT_HIGH = 4'h1;
  localparam logic [3:0] ADDR_MODE       = 4'h2;
  localparam logic [3:0] ADDR_STATUS     = 4'h3;
  localparam logic [3:0] ADDR_ENABLE     = 4'h4;
  localparam logic [3:0] ADDR_CYCLE_LEN  = 4'h5;

  // ---------------------------------------------------------------
  // Mode register fields
  // ---------------------------------------------------------------
  localparam int MODE_IDLE_BIT  = 7;
  localparam int MODE_WDOG_BIT  = 6;
  localparam int MODE_TB_LSB    = 1;
  localparam int MODE_OVF_IRQ   = 0;
  localparam logic [7:0] MODE_RESET = 8'h40;

  // Status and enable layout: bit 0 main, bit 1 mid, bits 4:2 channels
  localparam int ST_MAIN  = 0;
  localparam int ST_MID   = 1;
  localparam int ST_CH0   = 2;
  localparam int NUM_CH   = 3;
  localparam int NUM_EV   = 5;

  // ---------------------------------------------------------------
  // Timebase codes and dividers
  // ---------------------------------------------------------------
  typedef enum logic [2:0] {
    TB_DIV12  = 3'h0,
    TB_DIV4   = 3'h1,
    TB_TIMER  = 3'h2,
    TB_EXTIN  = 3'h3,
    TB_SYSCLK = 3'h4,
    TB_OSC8   = 3'h5
  } timebase_e;

  localparam logic [3:0] DIV12_LAST = 4'hb;
  localparam logic [3:0] DIV4_LAST  = 4'h3;
  localparam logic [1:0] OSC8_BIT   = 2'h2;
  localparam logic [2:0] CLSEL_BASE = 3'h0;

  // ---------------------------------------------------------------
  // Bus transaction carrier
  // ---------------------------------------------------------------
  typedef struct packed {
    logic        read;
    logic        write;
    logic [3:0]  address;
    logic [31:0] writedata;
  } bus_req_s;

endpackage : pca_pkg

`default_nettype wire

// file: rtl/pca_tick_gen.sv
// Timebase tick generator: picks one count enable pulse per cycle.
// Assumes raw pins (external count input, oscillator) are asynchronous.
`default_nettype none

module pca_tick_gen
  import pca_pkg::*;
(
  // Clock and reset
  input  wire logic       clk_sys,
  input  wire logic       reset,
  // Selection and sources
  input  wire logic [2:0] timebase_select,
  input  wire logic       timer_ovf,
  input  wire logic       ext_count_input,
  input  wire logic       ext_osc,
  // Result
  output logic            tick
);

  typedef struct packed {
    logic [3:0] div;
    logic [1:0] ext_sync;
    logic       ext_last;
    logic [2:0] osc_div;
    logic [1:0] osc_sync;
    logic       osc_last;
  } tick_state_s;

  tick_state_s st_r;
  tick_state_s st_nxt;
  logic        div_last;

  // ---------------------------------------------------------------
  // Next state
  // ---------------------------------------------------------------
  // Prescaler wraps at the length for the chosen division
  always_comb
  begin
    st_nxt = st_r;
    div_last = (timebase_select == TB_DIV12) ? (st_r.div == DIV12_LAST)
                                             : (st_r.div == DIV4_LAST);
    st_nxt.div = div_last ? 4'h0 : st_r.div + 4'h1;
    // Two flops before any edge logic reads the pin
    st_nxt.ext_sync = {st_r.ext_sync[0], ext_count_input};
    st_nxt.ext_last = st_r.ext_sync[1];
    // The divide by 8 runs in the system domain off a synchronised oscillator
    st_nxt.osc_sync = {st_r.osc_sync[0], ext_osc};
    st_nxt.osc_last = st_r.osc_sync[1];
    if (st_r.osc_sync[1] && !st_r.osc_last)
      st_nxt.osc_div = st_r.osc_div + 3'h1;
    tick = 1'b0;
    case (timebase_select)
      TB_DIV12:  tick = div_last;
      TB_DIV4:   tick = div_last;
      TB_TIMER:  tick = timer_ovf;
      TB_EXTIN:  tick = st_r.ext_last && !st_r.ext_sync[1];
      TB_SYSCLK: tick = 1'b1;
      TB_OSC8:   tick = st_r.osc_sync[1] && !st_r.osc_last
                        && (st_r.osc_div == {1'b1, OSC8_BIT});
      default:   tick = 1'b0;
    endcase
  end

  // Registered state, synchronous reset
  always_ff @(posedge clk_sys)
  begin
    if (reset)
      st_r <= '0;
    else
      st_r <= st_nxt;
  end

endmodule : pca_tick_gen

`default_nettype wire

// file: verif/pca_far_side.sv
// Source model for the far side of the counter: other timer, count pin,
// oscillator and channel logic. Assumes the bench calls its tasks.
`default_nettype none

module pca_far_side
(
  // Clock
  input  wire logic  clk_sys,
  // Sources into the block
  output logic       timer_ovf,
  output logic       ext_count_input,
  output logic       ext_osc,
  output logic [2:0] channel_event
);
  timeunit 1ns;
  timeprecision 1ns;

  // Oscillator runs free at 400 ns, phase offset from clk_sys
  initial
  begin
    timer_ovf = 1'b0;
    ext_count_input = 1'b1;
    ext_osc = 1'b0;
    channel_event = 3'h0;
    #37;
    forever #200 ext_osc = ~ext_osc;
  end

  // One-cycle overflow pulses from the other timer
  task automatic pulse_timer(input int n);
    repeat (n)
    begin
      @(posedge clk_sys) timer_ovf <= 1'b1;
      @(posedge clk_sys) timer_ovf <= 1'b0;
    end
  endtask : pulse_timer

  // Each level held 3 cycles, so the pin never beats a quarter of clk_sys
  task automatic send_edges(input int n);
    repeat (n)
    begin
      repeat (3) @(posedge clk_sys);
      ext_count_input <= 1'b0;
      repeat (3) @(posedge clk_sys);
      ext_count_input <= 1'b1;
    end
  endtask : send_edges

  // One-cycle event from a channel
  task automatic fire_channel(input int i);
    @(posedge clk_sys) channel_event <= 3'h1 << i;
    @(posedge clk_sys) channel_event <= 3'h0;
  endtask : fire_channel
endmodule : pca_far_side

`default_nettype wire

// file: verif/test_array_counter_timebase_irq.sv
// Bench for the counter core: bus, timebases, snapshot, flags and irq.
// Assumes pca_core as top and pca_far_side driving the count sources.
`default_nettype none

module test_array_counter_timebase_irq;
  import pca_pkg::*;
  timeunit 1ns;
  timeprecision 1ns;
  // ----------------------------------------
  // Signals, instances and helpers
  // ----------------------------------------
  logic        clk_sys, reset, read, write, cpu_idle;
  logic [3:0]  address;
  logic [31:0] writedata, readdata, q;
  logic        waitrequest, watchdog_function, irq, timer_ovf, ext_count_input, ext_osc;
  logic [2:0]  channel_event;
  logic        global_irq_switch, array_irq_switch;
  logic [15:0] count_value, c0, v;
  int          errors, tests_run, k;
  int unsigned rnd;
  int          per[4] = '{12, 4, 1, 32};
  timebase_e   tbc[4] = '{TB_DIV12, TB_DIV4, TB_SYSCLK, TB_OSC8};

  pca_core dut_u (.clk_sys, .reset, .address, .read, .write, .writedata, .readdata,
    .waitrequest, .timer_ovf, .ext_count_input, .ext_osc, .cpu_idle, .channel_event,
    .count_value, .watchdog_function, .irq);
  pca_far_side far_u (.clk_sys, .timer_ovf, .ext_count_input, .ext_osc, .channel_event);

  // System clock, 100 ns period
  always #50 clk_sys = ~clk_sys;

  // Verdict and end of run
  task automatic results();
    $display("Comparisons %0d mismatches %0d", tests_run, errors);
    if (errors == 0 && tests_run > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask : results

  // Compare and count
  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp)
    begin
      errors++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk

  // One bus cycle, held until waitrequest is sampled low at a rising edge; bounded wait
  task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk_sys);
    read      <= ~wr;
    write     <= wr;
    address   <= a;
    writedata <= d;
    do
    begin
      @(posedge clk_sys);
      n++;
      if (n > 40)
      begin
        errors++;
        results();
      end
    end
    while (waitrequest !== 1'b0);
    q = readdata;
    read  <= 1'b0;
    write <= 1'b0;
  endtask : bus

  task automatic rdc(input logic [3:0] a, input logic [31:0] exp, input string what);
    bus(1'b0, a, 32'h0);
    chk(what, q, exp);
  endtask : rdc

  // Preload with the source parked on the quiet timer input, so no count slips in
  task automatic setc(input logic [15:0] val);
    bus(1'b1, ADDR_MODE, 32'h04);
    bus(1'b1, ADDR_COUNT_LOW, {24'h0, val[7:0]});
    bus(1'b1, ADDR_COUNT_HIGH, {24'h0, val[15:8]});
  endtask : setc

  // Advance over whole divider periods is exact, once the prescaler has
  // come round after a switch; a switch from 12 to 4 stretches one period
  task automatic span(input int cyc, input logic [15:0] exp);
    repeat (16) @(negedge clk_sys);
    c0 = count_value;
    repeat (cyc) @(negedge clk_sys);
    chk("count step", 16'(count_value - c0), exp);
  endtask : span

  // The irq is decoded from registered flags and enables, so let it settle first
  task automatic irqis(input logic exp);
    repeat (2) @(negedge clk_sys);
    chk("irq", irq, exp);
  endtask : irqis

  // Main sequence
  initial
  begin
    clk_sys = 1'b0;
    reset = 1'b1;
    read = 1'b0;
    write = 1'b0;
    address = 4'h0;
    writedata = 32'h0;
    cpu_idle = 1'b0;
    global_irq_switch = 1'b1;
    array_irq_switch = 1'b0;
    errors = 0;
    tests_run = 0;
    rnd = $urandom(49);
    repeat (12) @(posedge clk_sys);
    reset <= 1'b0;
    rdc(ADDR_MODE, 32'h40, "mode reset");
    bus(1'b1, ADDR_MODE, 32'h44);
    rdc(ADDR_MODE, 32'h40, "mode locked");
    chk("watchdog on", watchdog_function, 1'b1);
    bus(1'b1, ADDR_MODE, 32'h04);
    @(negedge clk_sys);
    chk("watchdog off", watchdog_function, 1'b0);
    rdc(4'h6 + 4'($urandom_range(9)), 32'h0, "unmapped");
    $display("lock test done");
    v = 16'($urandom) & 16'h7fff | 16'h00ff;
    setc(v);
    rdc(ADDR_COUNT_LOW, 32'hff, "low");
    rdc(ADDR_COUNT_HIGH, {24'h0, v[15:8]}, "high");
    chk("held", count_value, v);
    rdc(ADDR_COUNT_LOW, 32'hff, "low again");
    far_u.pulse_timer(1);
    rdc(ADDR_COUNT_HIGH, {24'h0, v[15:8]}, "snapshot");
    chk("after reads", count_value, v + 16'h1);
    rdc(ADDR_COUNT_LOW, 32'h0, "low wrap");
    rdc(ADDR_COUNT_HIGH, {24'h0, v[15:8] + 8'h1}, "high fresh");
    $display("snapshot test done");
    k = 3 + $urandom_range(7);
    foreach (per[i])
    begin
      bus(1'b1, ADDR_MODE, {28'h0, tbc[i], 1'b0});
      span(per[i] * k, 16'(k));
    end
    bus(1'b1, ADDR_MODE, 32'h06);
    c0 = count_value;
    far_u.send_edges(k);
    repeat (6) @(negedge clk_sys);
    chk("pin edges", 16'(count_value - c0), k);
    bus(1'b1, ADDR_MODE, 32'h04);
    c0 = count_value;
    far_u.pulse_timer(k);
    repeat (4) @(negedge clk_sys);
    chk("timer beats", 16'(count_value - c0), k);
    $display("timebase test done");
    @(posedge clk_sys);
    cpu_idle <= 1'b1;
    bus(1'b1, ADDR_MODE, 32'h88);
    span(20, 16'h0);
    bus(1'b1, ADDR_MODE, 32'h08);
    span(20, 16'd20);
    @(posedge clk_sys);
    cpu_idle <= 1'b0;
    bus(1'b1, ADDR_MODE, 32'h88);
    span(20, 16'd20);
    $display("idle test done");
    bus(1'b1, ADDR_ENABLE, 32'h0);
    for (int s = 0; s < 8; s++)
    begin
      bus(1'b1, ADDR_CYCLE_LEN, 32'(s));
      setc(16'((32'h100 << s) - 8));
      bus(1'b1, ADDR_STATUS, 32'h1f);
      bus(1'b1, ADDR_MODE, 32'h08);
      repeat (12) @(negedge clk_sys);
      bus(1'b1, ADDR_MODE, 32'h04);
      rdc(ADDR_STATUS, 32'h2, "mid flag");
    end
    $display("mid flag test done");
    setc(16'hfff0);
    bus(1'b1, ADDR_STATUS, 32'h1f);
    bus(1'b1, ADDR_MODE, 32'h08);
    repeat (30) @(negedge clk_sys);
    bus(1'b1, ADDR_MODE, 32'h05);
    rdc(ADDR_STATUS, 32'h03, "wrap flags");
    irqis(1'b1);
    // The core only takes the request with both of its own switches on
    chk("core masked", irq && global_irq_switch && array_irq_switch, 1'b0);
    array_irq_switch = 1'b1;
    chk("core taken", irq && global_irq_switch && array_irq_switch, 1'b1);
    rdc(ADDR_STATUS, 32'h03, "flag kept");
    bus(1'b1, ADDR_STATUS, 32'h01);
    irqis(1'b0);
    bus(1'b1, ADDR_ENABLE, 32'h02);
    irqis(1'b1);
    bus(1'b1, ADDR_STATUS, 32'h02);
    irqis(1'b0);
    bus(1'b1, ADDR_ENABLE, 32'h0);
    for (int i = 0; i < 3; i++)
    begin
      far_u.fire_channel(i);
      rdc(ADDR_STATUS, 32'h4 << i, "channel flag");
      irqis(1'b0);
      bus(1'b1, ADDR_ENABLE, 32'h4 << i);
      irqis(1'b1);
      bus(1'b1, ADDR_STATUS, 32'h4 << i);
      irqis(1'b0);
    end
    $display("interrupt test done");
    results();
  end
endmodule : test_array_counter_timebase_irq

`default_nettype wire
